// file: bk3_pkg.sv
// Constants, types and field layout of the third buck regulator control bank.
package bk3_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] ADDR_MODE_CFG  = 8'h36;
	localparam logic [7:0] ADDR_PEAK_CFG  = 8'h37;
	localparam logic [7:0] ADDR_VOUT_CODE = 8'h38;
	localparam logic [7:0] ADDR_PIN_EN    = 8'h39;
	localparam logic [7:0] ADDR_DVS_SEL   = 8'h3a;

	// ==========================================================
	// Writable bit masks and reset values
	localparam logic [7:0] MASK_MODE_CFG  = 8'h78;
	localparam logic [7:0] MASK_PEAK_CFG  = 8'h8f;
	localparam logic [7:0] MASK_VOUT_CODE = 8'h3f;
	localparam logic [7:0] MASK_PIN_EN    = 8'hff;
	localparam logic [7:0] MASK_DVS_SEL   = 8'h1f;
	localparam logic [7:0] RESET_BYTE     = 8'h00;

	// ==========================================================
	// Field positions
	localparam int BIT_DROPOUT_DIS  = 6;
	localparam int BIT_PIN_FAST     = 5;
	localparam int BIT_FORCED_PWM   = 4;
	localparam int BIT_ADAPT_DIS    = 3;
	localparam int BIT_LOOKUP_DIS   = 7;
	localparam int FAST_PIN_INDEX   = 4;
	localparam int NUM_PINS         = 8;

	// ==========================================================
	// Field codes
	localparam logic [2:0] SEQ_BY_ENABLE_FIELD = 3'h7;
	typedef enum logic [1:0] {
		BK3_EN_OFF = 2'h0,
		BK3_EN_ON  = 2'h1,
		BK3_EN_PIN = 2'h2,
		BK3_EN_RSV = 2'h3
	} bk3_en_t;
	localparam logic [4:0] DVS_OFF_CODE    = 5'h00;
	localparam logic [4:0] DVS_LAST_PAIR   = 5'h1c;
	localparam logic [4:0] DVS_SERIAL_CODE = 5'h1d;

	// ==========================================================
	// Analog scales in mA and mV
	localparam logic [8:0]  PEAK_STEP_MA = 9'h019;
	localparam logic [12:0] VOUT_BASE_MV = 13'h0226;
	localparam logic [12:0] VOUT_STEP_MV = 13'h0032;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} bk3_reg_req_t;

	typedef struct packed {
		logic       ldo_enable;
		logic       fast_mode;
		logic       forced_pwm;
		logic       adaptive_current;
		logic       current_from_field;
		logic [8:0] peak_current_ma;
		logic [12:0] vout_mv;
	} bk3_mode_t;

	typedef struct packed {
		logic       enable_valid;
		logic       regulator_enable;
		logic       dvs_pin_mode;
		logic       dvs_serial_mode;
		logic [1:0] dvs_setting;
	} bk3_ctl_t;

endpackage

// file: bk3_pin_sync.sv
// Two-stage synchroniser for the multipurpose control pins.
module bk3_pin_sync (
	input  wire logic                       clk,
	input  wire logic                       reset,
	input  wire logic [bk3_pkg::NUM_PINS-1:0] pin_async,
	output logic      [bk3_pkg::NUM_PINS-1:0] pin_sync
);
	import bk3_pkg::*;

	// ==========================================================
	// Per pin synchroniser
	// The first stage feeds only the second stage, so nothing downstream sees a metastable level.
	genvar i;
	generate
		for (i = 0; i < NUM_PINS; i++)
		begin : g_sync
			logic meta_reg;
			always_ff @(posedge clk or posedge reset)
			begin
				if (reset)
				begin
					meta_reg    <= 1'b0;
					pin_sync[i] <= 1'b0;
				end
				else
				begin
					meta_reg    <= pin_async[i];
					pin_sync[i] <= meta_reg;
				end
			end
		end
	endgenerate

endmodule

// file: bk3_regs.sv
// Register bank and control decode of the third buck regulator.
module bk3_regs (
	input  wire logic                       clk,
	input  wire logic                       reset,
	input  wire bk3_pkg::bk3_reg_req_t      reg_req,
	output logic      [7:0]                 reg_rdata,
	output logic                            reg_rd_valid,
	input  wire logic [bk3_pkg::NUM_PINS-1:0] mpc_pins,
	input  wire logic [2:0]                 sequence_field,
	input  wire logic [1:0]                 enable_field,
	output bk3_pkg::bk3_mode_t              mode_out,
	output bk3_pkg::bk3_ctl_t               ctl_out
);
	import bk3_pkg::*;

	// ==========================================================
	// Storage
	logic [7:0] mode_cfg_reg;
	logic [7:0] peak_cfg_reg;
	logic [7:0] vout_code_reg;
	logic [7:0] pin_en_reg;
	logic [7:0] dvs_sel_reg;
	logic [NUM_PINS-1:0] pins_s;

	bk3_pin_sync u_sync (
		.clk       (clk),
		.reset     (reset),
		.pin_async (mpc_pins),
		.pin_sync  (pins_s)
	);

	// ==========================================================
	// Address decode
	wire hit_mode = reg_req.addr == ADDR_MODE_CFG;
	wire hit_peak = reg_req.addr == ADDR_PEAK_CFG;
	wire hit_vout = reg_req.addr == ADDR_VOUT_CODE;
	wire hit_pin  = reg_req.addr == ADDR_PIN_EN;
	wire hit_dvs  = reg_req.addr == ADDR_DVS_SEL;

	logic [7:0] rd_mux;
	always_comb
	begin
		if (hit_mode)
			rd_mux = mode_cfg_reg;
		else if (hit_peak)
			rd_mux = peak_cfg_reg;
		else if (hit_vout)
			rd_mux = vout_code_reg;
		else if (hit_pin)
			rd_mux = pin_en_reg;
		else if (hit_dvs)
			rd_mux = dvs_sel_reg;
		else
			rd_mux = RESET_BYTE;
	end

	// Unassigned positions are masked on write, so they always read back as zero.
	wire [7:0] wmask_data = reg_req.wdata;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			mode_cfg_reg  <= RESET_BYTE;
			peak_cfg_reg  <= RESET_BYTE;
			vout_code_reg <= RESET_BYTE;
			pin_en_reg    <= RESET_BYTE;
			dvs_sel_reg   <= RESET_BYTE;
			reg_rdata     <= RESET_BYTE;
			reg_rd_valid  <= 1'b0;
		end
		else
		begin
			if (reg_req.wr && hit_mode)
				mode_cfg_reg <= wmask_data & MASK_MODE_CFG;
			if (reg_req.wr && hit_peak)
				peak_cfg_reg <= wmask_data & MASK_PEAK_CFG;
			if (reg_req.wr && hit_vout)
				vout_code_reg <= wmask_data & MASK_VOUT_CODE;
			if (reg_req.wr && hit_pin)
				pin_en_reg <= wmask_data & MASK_PIN_EN;
			if (reg_req.wr && hit_dvs)
				dvs_sel_reg <= wmask_data & MASK_DVS_SEL;
			reg_rdata    <= reg_req.rd ? rd_mux : RESET_BYTE;
			reg_rd_valid <= reg_req.rd;
		end
	end

	// ==========================================================
	// Regulator mode decode
	wire       lookup_dis = peak_cfg_reg[BIT_LOOKUP_DIS];
	wire [3:0] peak_code  = peak_cfg_reg[3:0];
	wire [5:0] vout_code  = vout_code_reg[5:0];
	wire       field_used = lookup_dis | mode_cfg_reg[BIT_ADAPT_DIS];

	bk3_mode_t mode_next;
	assign mode_next.ldo_enable         = ~mode_cfg_reg[BIT_DROPOUT_DIS];
	assign mode_next.fast_mode          = mode_cfg_reg[BIT_PIN_FAST] & pins_s[FAST_PIN_INDEX];
	assign mode_next.forced_pwm         = mode_cfg_reg[BIT_FORCED_PWM];
	assign mode_next.adaptive_current   = ~mode_cfg_reg[BIT_ADAPT_DIS];
	// Only the lookup-disable bit hands the current limit to the field; adaptive disable alone does not.
	assign mode_next.current_from_field = lookup_dis;
	// The field is reported as zero unless the lookup-disable or the adaptive-disable bit is set.
	assign mode_next.peak_current_ma    = field_used ? 9'({5'h00, peak_code} * PEAK_STEP_MA) : 9'h000;
	assign mode_next.vout_mv            = 13'(VOUT_BASE_MV + 13'({7'h00, vout_code} * VOUT_STEP_MV));

	// ==========================================================
	// Enable and scaling decode
	wire       seq_ok   = sequence_field == SEQ_BY_ENABLE_FIELD;
	wire       pin_or   = |(pin_en_reg & pins_s);
	wire [4:0] dvs_code = dvs_sel_reg[4:0];

	logic       en_next;
	logic [2:0] pair_lo;
	logic [2:0] pair_hi;
	always_comb
	begin
		case (bk3_en_t'(enable_field))
			BK3_EN_ON:  en_next = 1'b1;
			BK3_EN_PIN: en_next = pin_or;
			default:    en_next = 1'b0;
		endcase
	end

	// Walks the pairs in ascending order; a code outside the pair range leaves pin pair (0,0).
	always_comb
	begin
		logic [4:0] idx;
		idx     = 5'h00;
		pair_lo = 3'h0;
		pair_hi = 3'h0;
		for (int a = 0; a < NUM_PINS; a++)
			for (int b = a + 1; b < NUM_PINS; b++)
			begin
				idx = 5'(idx + 5'h01);
				if (idx == dvs_code)
				begin
					pair_lo = 3'(a);
					pair_hi = 3'(b);
				end
			end
	end

	wire pair_mode = dvs_code != DVS_OFF_CODE && dvs_code <= DVS_LAST_PAIR;

	bk3_ctl_t ctl_next;
	assign ctl_next.enable_valid     = seq_ok;
	assign ctl_next.regulator_enable = seq_ok & en_next;
	assign ctl_next.dvs_pin_mode     = pair_mode;
	assign ctl_next.dvs_serial_mode  = dvs_code == DVS_SERIAL_CODE;
	assign ctl_next.dvs_setting      = pair_mode ? {pins_s[pair_hi], pins_s[pair_lo]} : 2'h0;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			mode_out <= '0;
			ctl_out  <= '0;
		end
		else
		begin
			mode_out <= mode_next;
			ctl_out  <= ctl_next;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_ldo_follows_bit: assert property (reg_req.wr && hit_mode ##2 1 |->
		mode_out.ldo_enable == ~$past(reg_req.wdata[BIT_DROPOUT_DIS], 2))
		else $error("Dropout mode does not follow its disable bit.");
	a_fast_pin_gate: assert property (!mode_cfg_reg[BIT_PIN_FAST] |=> !mode_out.fast_mode)
		else $error("Fast mode active while pin control is off.");
	a_pwm_mode_bit: assert property (mode_cfg_reg[BIT_FORCED_PWM] |=> mode_out.forced_pwm)
		else $error("Forced PWM not applied.");
	a_peak_field_scale: assert property (lookup_dis && peak_code == 4'hf |=> mode_out.peak_current_ma == 9'h177)
		else $error("Peak current code fifteen is not 375mA.");
	a_lookup_owns: assert property (!lookup_dis && !mode_cfg_reg[BIT_ADAPT_DIS] |=>
		!mode_out.current_from_field && mode_out.peak_current_ma == 9'h000)
		else $error("Field used while lookup table selected.");
	a_vout_top_code: assert property (vout_code == 6'h3f |=> mode_out.vout_mv == 13'h0e74)
		else $error("Full-scale voltage code is not 3.7V.");
	a_pin_enable_or: assert property (seq_ok && enable_field == BK3_EN_PIN |=>
		ctl_out.regulator_enable == |($past(pin_en_reg) & $past(pins_s)))
		else $error("Pin-controlled enable is not the OR of selected pins.");
	a_seq_gate_enable: assert property (!seq_ok |=> !ctl_out.regulator_enable)
		else $error("Enable decoded outside sequence code 111.");
	a_dvs_off_code: assert property (dvs_code == DVS_OFF_CODE |=>
		!ctl_out.dvs_pin_mode && !ctl_out.dvs_serial_mode)
		else $error("Scaling active with selection code zero.");
	a_first_pair: assert property (dvs_code == 5'h01 |=>
		ctl_out.dvs_setting == {$past(pins_s[1]), $past(pins_s[0])})
		else $error("Pair code one does not follow pins zero and one.");
	a_unused_read_zero: assert property (reg_req.rd && hit_mode |=>
		reg_rdata[7] == 1'b0 && reg_rdata[2:0] == 3'h0)
		else $error("Unassigned bits read nonzero.");
	a_pin_latency: assert property ((mode_cfg_reg[BIT_PIN_FAST] && $stable(mpc_pins[FAST_PIN_INDEX])) [*3] |=>
		mode_out.fast_mode == $past(mpc_pins[FAST_PIN_INDEX], 1))
		else $error("Fast mode does not track the synchronised pin.");

endmodule

// file: bk3_host_model.sv
// Host model that writes and reads the bank and drives the multipurpose pins.
module bk3_host_model (
	input  wire logic            clk,
	output bk3_pkg::bk3_reg_req_t req,
	output logic [7:0]           pins,
	input  wire logic [7:0]      rdata,
	input  wire logic            rvld
);
	timeunit 1ns;
	timeprecision 1ps;
	import bk3_pkg::*;
	// ==========================================================
	// Bus cycles
	initial
	begin
		req = '0;
		pins = 8'h00;
	end
	// Peak current codes are not policed; any code may be sent.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk);
		// Idle address and data are inverted so no stale value looks valid.
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(negedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk);
		d = rdata;
		v = rvld;
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
	endtask
	task automatic pins_to(input logic [7:0] v);
		@(negedge clk);
		pins <= v;
	endtask
endmodule

// file: test_buck_regulator_control_regs.sv
// Self-checking bench of the third buck regulator control bank.
module test_buck_regulator_control_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import bk3_pkg::*;
	// ==========================================================
	// Signals and instances
	logic                  clk = 1'b0;
	logic                  reset = 1'b1;
	logic [2:0]            seq = 3'h0;
	logic [1:0]            en = 2'h0;
	bk3_reg_req_t          req;
	logic [7:0]            pins;
	logic [7:0]            rdata;
	logic                  rvld;
	bk3_mode_t             mo;
	bk3_ctl_t              co;
	logic [7:0]            mir [5];
	int                    bad_count = 0;
	int                    n_checks = 0;
	localparam logic [7:0] MSK [5] = '{MASK_MODE_CFG, MASK_PEAK_CFG, MASK_VOUT_CODE, MASK_PIN_EN, MASK_DVS_SEL};
	always #20 clk = ~clk;
	bk3_host_model host (.clk(clk), .req(req), .pins(pins), .rdata(rdata), .rvld(rvld));
	bk3_regs dut_u (.clk(clk), .reset(reset), .reg_req(req), .reg_rdata(rdata), .reg_rd_valid(rvld),
		.mpc_pins(pins), .sequence_field(seq), .enable_field(en), .mode_out(mo), .ctl_out(co));
	// ==========================================================
	// Checking
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("Counts: %0d checks, %0d mismatches", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Reference decode of every output from the mirror, pins and fields.
	task automatic cmp_out;
		bk3_mode_t em;
		bk3_ctl_t  ec;
		int        k;
		em.ldo_enable = !mir[0][6];
		em.fast_mode = mir[0][5] & pins[4];
		em.forced_pwm = mir[0][4];
		em.adaptive_current = !mir[0][3];
		em.current_from_field = mir[1][7];
		em.peak_current_ma = (mir[1][7] | mir[0][3]) ? 9'(mir[1][3:0] * 25) : 9'h000;
		em.vout_mv = 13'(550 + mir[2][5:0] * 50);
		ec = '0;
		ec.enable_valid = (seq === 3'h7);
		ec.regulator_enable = ec.enable_valid & ((en === 2'h1) | ((en === 2'h2) & (|(pins & mir[3]))));
		k = 0;
		for (int i = 0; i < 8; i++)
			for (int j = i + 1; j < 8; j++)
			begin
				k++;
				if (k == mir[4])
				begin
					ec.dvs_pin_mode = 1'b1;
					ec.dvs_setting = {pins[j], pins[i]};
				end
			end
		ec.dvs_serial_mode = (mir[4] == 29);
		chk(32'(mo), 32'(em));
		chk(32'(co), 32'(ec));
	endtask
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		host.wr(a, d);
		if (a >= 8'h36 && a <= 8'h3a)
			mir[a - 8'h36] = d & MSK[a - 8'h36];
	endtask
	task automatic readback(input logic [7:0] a);
		logic [7:0] d;
		logic       v;
		host.rd(a, d, v);
		chk(32'(v), 32'h0000_0001);
		chk(32'(d), (a >= 8'h36 && a <= 8'h3a) ? 32'(mir[a - 8'h36]) : 32'h0000_0000);
	endtask
	task automatic settle;
		repeat (4) @(negedge clk);
		cmp_out();
	endtask
	// ==========================================================
	// Tests
	initial
	begin
		repeat (20000) @(posedge clk);
		bad_count++;
		print_verdict();
	end
	initial
	begin
		for (int i = 0; i < 5; i++)
			mir[i] = RESET_BYTE;
		void'($urandom(9));
		repeat (2) @(negedge clk);
		reset = 1'b0;
		for (int a = 8'h36; a <= 8'h3a; a++)
			readback(8'(a));
		settle();
		$display("Test reset values finished");
		// Random writes, including unmapped places, with random pins and fields.
		repeat (150)
		begin
			put(8'(8'h34 + $urandom_range(0, 8)), 8'($urandom));
			host.pins_to(8'($urandom));
			@(negedge clk);
			seq <= ($urandom_range(0, 3) == 0) ? 3'($urandom) : 3'h7;
			en <= 2'($urandom);
			settle();
			readback(8'(8'h34 + $urandom_range(0, 8)));
		end
		$display("Test random traffic finished");
		// Every scaling code and every enable code.
		for (int c = 0; c < 32; c++)
		begin
			put(ADDR_DVS_SEL, 8'(c));
			host.pins_to(8'($urandom));
			@(negedge clk);
			seq <= 3'h7;
			en <= 2'(c);
			settle();
		end
		$display("Test scaling codes finished");
		print_verdict();
	end
endmodule
